// [pkg/csc_pkg.sv]
/*
 Shared constants and types for the line-access front end: register map,
 field positions, sample-count thresholds and receive states.
 Assumes one sample per clock, eight samples per bit time.
*/
package csc_pkg;
	// Bit timing
	localparam int SAMPLES_PER_BIT = 8;
	localparam int IFS_ZERO_BITS   = 256;   // Length when register holds zero
	// Register byte offsets
	localparam logic [3:0] OFF_IFS    = 4'h0;
	localparam logic [3:0] OFF_CTRL   = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h8;
	localparam logic [3:0] OFF_RXDATA = 4'hC;
	localparam logic [7:0] IFS_RESET  = 8'h00;
	// Status bit positions
	localparam int ST_LINE_IDLE   = 0;
	localparam int ST_RX_ABORT    = 1;
	localparam int ST_COLLISION   = 2;
	localparam int ST_IFS_DONE    = 3;
	localparam int ST_UNSUPPORTED = 4;
	localparam int ST_RECEIVING   = 5;
	// Decoder thresholds, in samples
	localparam logic [4:0] MIN_RUN       = 5'd3;   // Shorter level is a narrow pulse
	localparam logic [4:0] LONG_RUN      = 5'd6;   // Run this long ends at mid-cell
	localparam logic [4:0] EDGE_LOW_BAD  = 5'd6;   // Low after edge fall, no rise
	localparam logic [4:0] MID_LOW_BAD   = 5'd11;  // Low after mid fall, no rise
	localparam logic [4:0] HIGH_MISS     = 5'd11;  // High without expected fall
	localparam logic [4:0] HIGH_EOF      = 5'd18;  // Second missing fall: idle
	localparam logic [4:0] RUN_MAX       = 5'd31;
	// Recognition delays, in samples
	localparam logic [3:0] DLY_NARROW    = 4'd3;
	localparam logic [3:0] DLY_EDGE_LOW  = 4'd2;
	localparam logic [3:0] DLY_MID_LOW   = 4'd2;
	localparam logic [3:0] DLY_FALSE_EOF = 4'd4;
	// Strip buffer lengths
	localparam logic [5:0] CRC16_LEN = 6'd16;
	localparam logic [5:0] CRC32_LEN = 6'd32;
	localparam logic [2:0] BYTE_LAST = 3'd7;

	// Software control fields
	typedef struct packed {
		logic       receiver_enable_bit;
		logic       crc32_sel;
		logic       deterministic_resolution_select;
		logic [1:0] backoff_mode;   // 00 normal, 11 alternate
		logic       ext_clk_sel;
		logic       csma_mode;
	} csc_ctrl_t;
	localparam csc_ctrl_t CTRL_RESET = '0;

	// Received byte toward the receive FIFO
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} csc_rx_byte_t;

	typedef enum logic [1:0] {
		RX_HUNT     = 2'b00,
		RX_PREAMBLE = 2'b01,
		RX_DATA     = 2'b10,
		RX_SKIP     = 2'b11
	} csc_rx_state_t;
endpackage

// [hw/csc_line_access.sv]
/*
 CSMA/CD line-access front end: interframe-space deferral, Manchester
 decoding with oversampled collision detection, receive-side collision
 response. Registers over Avalon-MM with waitrequest.
 Assumes clk is the sample clock (8 samples per bit), the receive pin is
 asynchronous, and transmit jam/backoff and the receive FIFO lie outside.
*/
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module csc_line_access
	import csc_pkg::*;
#(
	parameter int STRIP_MAX = 32
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Line and transmitter
	input  wire logic        serial_receive_pin,
	input  wire logic        tx_start,
	input  wire logic        tx_active,
	output logic             tx_permit,
	output logic             manchester_sel,
	// Collision events
	output logic             collision,
	output logic             resolution_join,
	// Toward the receive FIFO
	output csc_rx_byte_t     rx_byte
);
	// Register state
	logic [6:0]    ifs_hi;
	csc_ctrl_t     ctrl;
	logic          line_idle_flag;
	logic          receive_abort_error_flag;
	logic          collision_seen;
	// Line sampling and decoder
	logic          rx_s1, rx_s2, rx_prev;
	logic [4:0]    run_cnt;
	logic          in_frame, last_mid, eof_pend;
	logic [3:0]    col_cnt;
	// Interframe space
	logic [8:0]    ifs_bits;
	logic [2:0]    ifs_sub;
	logic          ifs_run;
	// Receiver
	csc_rx_state_t rx_state;
	logic          prev_bit, byte_stored;
	logic [STRIP_MAX-1:0] strip;
	logic [5:0]    strip_cnt;
	logic [7:0]    rx_sr;
	logic [2:0]    bit_cnt;

	// Register index decode, shared by read and write paths
	function automatic logic [2:0] reg_sel(input logic [3:0] a);
		if (a == OFF_IFS)
			return 3'd1;
		else if (a == OFF_CTRL)
			return 3'd2;
		else if (a == OFF_STATUS)
			return 3'd3;
		else if (a == OFF_RXDATA)
			return 3'd4;
		else
			return 3'd0;
	endfunction

	// Derived combinational terms
	logic       edge_now, is_mid, man_en, carrier, normal_bo, bus_wr, bus_rd;
	logic       first_half, dec_valid, strip_out, col_fire;
	logic [8:0] ifs_total;
	logic [2:0] sel;
	logic [3:0] col_detect;
	assign sel      = reg_sel(avs_address);
	assign bus_wr   = avs_write && !avs_waitrequest;
	assign bus_rd   = avs_read && !avs_waitrequest;
	assign edge_now = rx_s2 != rx_prev;
	assign man_en   = ctrl.csma_mode && !ctrl.ext_clk_sel;
	assign carrier  = in_frame;
	assign normal_bo = (ctrl.backoff_mode == 2'b00) && !ctrl.deterministic_resolution_select;
	assign ifs_total = (ifs_hi == 7'd0) ? 9'(IFS_ZERO_BITS) : {1'b0, ifs_hi, 1'b0};
	// low bit shows the first half
	assign first_half = ifs_run && ({1'b0, ifs_bits} > {1'b0, ifs_total[8:1], 1'b0} >> 1);
	// after a long run the transition is mid-cell
	assign is_mid    = in_frame && ((run_cnt >= LONG_RUN) || !last_mid);
	assign dec_valid = man_en && edge_now && is_mid;
	assign col_fire  = col_cnt == 4'd1;
	// strip buffer exit follows the CRC length
	assign strip_out = ctrl.crc32_sel ? strip[CRC32_LEN-1] : strip[CRC16_LEN-1];

	// Violation classifier, value is the recognition delay or zero
	always_comb begin
		col_detect = 4'd0;
		if (man_en && in_frame) begin
			if (edge_now && run_cnt < MIN_RUN)
				col_detect = DLY_NARROW;
			// no rise after an edge fall
			else if (!edge_now && !rx_s2 && !last_mid && run_cnt == EDGE_LOW_BAD)
				col_detect = DLY_EDGE_LOW;
			// no rise after a mid fall
			else if (!edge_now && !rx_s2 && last_mid && run_cnt == MID_LOW_BAD)
				col_detect = DLY_MID_LOW;
			// fall while an end of frame is pending
			else if (edge_now && !rx_s2 && eof_pend)
				col_detect = DLY_FALSE_EOF;
		end
	end

	// Two-stage synchroniser, then history stage
	// one sample per clock
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_s1   <= 1'b1;
			rx_s2   <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			rx_s1   <= serial_receive_pin;
			rx_s2   <= rx_s1;
			rx_prev <= rx_s2;
		end
	end

	// Run length and transition type tracking
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			run_cnt  <= RUN_MAX;
			last_mid <= 1'b0;
		end else if (edge_now) begin
			run_cnt  <= 5'd1;
			last_mid <= is_mid;
		end else if (run_cnt != RUN_MAX) begin
			run_cnt  <= run_cnt + 5'd1;
		end
	end

	// Frame activity and end-of-frame detection
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			in_frame <= 1'b0;
			eof_pend <= 1'b0;
		end else if (edge_now) begin
			in_frame <= man_en || in_frame;
			eof_pend <= 1'b0;
		// second missing fall declares the end
		end else if (rx_s2 && run_cnt == HIGH_EOF) begin
			in_frame <= 1'b0;
			eof_pend <= 1'b0;
		end else if (rx_s2 && in_frame && run_cnt == HIGH_MISS) begin
			eof_pend <= 1'b1;
		end
	end

	// Recognition delay and collision pulse
	// runs whatever the channel is doing
	always_ff @(posedge clk) begin
		if (sys_rst)
			col_cnt <= 4'd0;
		else if (col_detect != 4'd0 && col_cnt == 4'd0)
			col_cnt <= col_detect;
		else if (col_cnt != 4'd0)
			col_cnt <= col_cnt - 4'd1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			collision       <= 1'b0;
			resolution_join <= 1'b0;
		end else begin
			collision       <= col_fire;
			resolution_join <= col_fire && ctrl.deterministic_resolution_select && !tx_active;
		end
	end

	// Interframe space timer
	// runs in every line mode
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			// first transmit held off 256 bit times
			ifs_run   <= 1'b1;
			ifs_bits  <= 9'(IFS_ZERO_BITS);
			ifs_sub   <= 3'd0;
			tx_permit <= 1'b0;
		end else if (tx_start) begin
			ifs_run   <= 1'b0;
			tx_permit <= 1'b0;
		end else if (!ifs_run && !tx_permit) begin
			// wait for the line to go quiet, then a full space
			if (!carrier) begin
				ifs_run  <= 1'b1;
				ifs_bits <= ifs_total;
				ifs_sub  <= 3'd0;
			end
		end else if (ifs_run) begin
			// only normal backoff restarts in the first half
			if (carrier && first_half && normal_bo) begin
				ifs_run <= 1'b0;
			end else begin
				ifs_sub <= ifs_sub + 3'd1;
				if (ifs_sub == 3'(SAMPLES_PER_BIT - 1)) begin
					ifs_bits <= ifs_bits - 9'd1;
					// expiry permits transmit regardless of carrier
					if (ifs_bits == 9'd1) begin
						ifs_run   <= 1'b0;
						tx_permit <= 1'b1;
					end
				end
			end
		end
	end

	// Receive framing, strip buffer and byte assembly
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_state    <= RX_HUNT;
			prev_bit    <= 1'b0;
			byte_stored <= 1'b0;
			strip       <= '0;
			strip_cnt   <= 6'd0;
			rx_sr       <= 8'h00;
			bit_cnt     <= 3'd0;
			rx_byte     <= '0;
		end else begin
			rx_byte.valid <= 1'b0;
			// collision aborts the frame in every receive state except RX_HUNT
			if (col_fire && rx_state != RX_HUNT) begin
				rx_state <= RX_HUNT;
			end else if (!in_frame) begin
				rx_state <= RX_HUNT;
			end else begin
				case (rx_state)
					RX_HUNT: begin
						if (ctrl.receiver_enable_bit && dec_valid) begin
							rx_state    <= RX_PREAMBLE;
							prev_bit    <= rx_s2;
							byte_stored <= 1'b0;
							strip_cnt   <= 6'd0;
							bit_cnt     <= 3'd0;
						end
					end
					RX_PREAMBLE: begin
						// Two ones close the preamble; two zeros spoil it
						if (dec_valid) begin
							prev_bit <= rx_s2;
							if (rx_s2 && prev_bit)
								rx_state <= RX_DATA;
							else if (!rx_s2 && !prev_bit)
								rx_state <= RX_SKIP;
						end
					end
					RX_DATA: begin
						// mid-cell decision lands half a bit late
						if (dec_valid) begin
							strip <= {strip[STRIP_MAX-2:0], rx_s2};
							if (strip_cnt != (ctrl.crc32_sel ? CRC32_LEN : CRC16_LEN)) begin
								strip_cnt <= strip_cnt + 6'd1;
							end else begin
								// first bit lands in the low bit
								rx_sr   <= {strip_out, rx_sr[7:1]};
								bit_cnt <= bit_cnt + 3'd1;
								if (bit_cnt == BYTE_LAST) begin
									rx_byte.valid <= 1'b1;
									rx_byte.data  <= {strip_out, rx_sr[7:1]};
									byte_stored   <= 1'b1;
								end
							end
						end
					end
					RX_SKIP: begin
						rx_state <= RX_SKIP;
					end
					default: begin
						rx_state <= RX_HUNT;
					end
				endcase
			end
		end
	end

	// Bus handshake: one wait cycle, then answer
	always_ff @(posedge clk) begin
		if (sys_rst)
			avs_waitrequest <= 1'b1;
		else if ((avs_read || avs_write) && avs_waitrequest)
			avs_waitrequest <= 1'b0;
		else
			avs_waitrequest <= 1'b1;
	end

	// Read data, taken while the request waits
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= 32'h0000_0000;
			case (sel)
				3'd1: avs_readdata[7:0] <= {ifs_hi, first_half};
				3'd2: avs_readdata[6:0] <= ctrl;
				3'd3: begin
					avs_readdata[ST_LINE_IDLE]   <= line_idle_flag;
					avs_readdata[ST_RX_ABORT]    <= receive_abort_error_flag;
					avs_readdata[ST_COLLISION]   <= collision_seen;
					avs_readdata[ST_IFS_DONE]    <= tx_permit;
					avs_readdata[ST_UNSUPPORTED] <= ctrl.csma_mode && ctrl.ext_clk_sel;
					avs_readdata[ST_RECEIVING]   <= rx_state != RX_HUNT;
				end
				3'd4: avs_readdata[7:0] <= rx_byte.data;
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Interframe space register
	// only even values reach the timer
	always_ff @(posedge clk) begin
		if (sys_rst)
			ifs_hi <= IFS_RESET[7:1];
		else if (bus_wr && avs_byteenable[0] && sel == 3'd1)
			ifs_hi <= avs_writedata[7:1];
	end

	// Control register; hardware clears receiver enable on late abort
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl <= CTRL_RESET;
		end else begin
			if (bus_wr && avs_byteenable[0] && sel == 3'd2)
				ctrl <= avs_writedata[6:0];
			if (col_fire && rx_state != RX_HUNT && byte_stored)
				ctrl.receiver_enable_bit <= 1'b0;
		end
	end

	// Sticky status, write one to clear, set wins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			line_idle_flag           <= 1'b0;
			receive_abort_error_flag <= 1'b0;
			collision_seen           <= 1'b0;
		end else begin
			if (bus_wr && avs_byteenable[0] && sel == 3'd3) begin
				if (avs_writedata[ST_LINE_IDLE])
					line_idle_flag <= 1'b0;
				if (avs_writedata[ST_RX_ABORT])
					receive_abort_error_flag <= 1'b0;
				if (avs_writedata[ST_COLLISION])
					collision_seen <= 1'b0;
			end
			if (!edge_now && rx_s2 && in_frame && run_cnt == HIGH_EOF)
				line_idle_flag <= 1'b1;
			// abort flag after a stored byte
			if (col_fire && rx_state != RX_HUNT && byte_stored)
				receive_abort_error_flag <= 1'b1;
			if (col_fire)
				collision_seen <= 1'b1;
		end
	end

	// Coding select output
	always_ff @(posedge clk) begin
		if (sys_rst)
			manchester_sel <= 1'b0;
		else
			manchester_sel <= man_en;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_narrow;
		edge_now && in_frame && man_en && run_cnt < MIN_RUN && col_cnt == 4'd0;
	endsequence

	a_narrow_pulse: assert property (s_narrow |-> ##4 collision)
		else $error("narrow pulse collision not flagged in time");
	a_edge_low: assert property (man_en && in_frame && !edge_now && !rx_s2 && !last_mid
		&& run_cnt == EDGE_LOW_BAD && col_cnt == 4'd0 |-> ##3 collision)
		else $error("edge fall without rise not flagged");
	a_mid_low: assert property (man_en && in_frame && !edge_now && !rx_s2 && last_mid
		&& run_cnt == MID_LOW_BAD && col_cnt == 4'd0 |-> ##3 collision)
		else $error("mid fall without rise not flagged");
	a_pulse_one: assert property (collision |=> !collision)
		else $error("collision pulse longer than one cycle");
	a_late_abort: assert property (col_fire && rx_state != RX_HUNT && byte_stored
		|=> receive_abort_error_flag && !ctrl.receiver_enable_bit)
		else $error("late collision did not abort receiver");
	a_early_abort: assert property (col_fire && rx_state != RX_HUNT && !byte_stored
		&& !receive_abort_error_flag && !bus_wr |=> rx_state == RX_HUNT && !receive_abort_error_flag)
		else $error("early collision not silent");
	a_join_dcr: assert property (collision && !resolution_join
		|-> !$past(ctrl.deterministic_resolution_select) || $past(tx_active))
		else $error("deterministic join missing");
	a_permit_hold: assert property (tx_permit && !tx_start |=> tx_permit)
		else $error("permit withdrawn by line activity");
	a_alt_keep: assert property (ifs_run && carrier && !normal_bo && !tx_start
		|=> ifs_run || tx_permit)
		else $error("space restarted outside normal backoff");
	a_zero_len: assert property (!ifs_run && !tx_permit && !carrier && !tx_start && ifs_hi == 7'd0
		|=> ifs_bits == 9'd256)
		else $error("zero register did not give 256 bits");
	a_nrz_ext: assert property (ctrl.ext_clk_sel |=> !manchester_sel)
		else $error("external clock did not force NRZ");
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer not after one wait cycle");
endmodule // csc_line_access

// [sim/csc_line_station.sv]
/*
 Far-side station model: drives Manchester frames and faults on the receive pin.
 Assumes its tasks are entered just after a rising clk edge; the line idles high.
*/
`timescale 1ns/1ps
module csc_line_station (
	// Sample clock
	input  wire logic clk,
	// Shared line toward the receiver
	output logic      line
);
	// Line starts high, its idle level
	initial line = 1'b1;

	// Hold one level for n samples
	task automatic half(input logic lv, input int n);
		line <= lv;
		repeat (n) @(posedge clk);
	endtask

	task automatic bit_out(input logic b);
		half(!b, 4);
		half(b, 4);
	endtask

	task automatic byte_out(input logic [7:0] d);
		for (int i = 0; i < 8; i++) bit_out(d[i]);
	endtask

	task automatic crc_out(input logic [31:0] c, input int n);
		for (int i = n - 1; i >= 0; i--) bit_out(c[i]);
	endtask

	// Alternating preamble closed by two ones
	task automatic preamble();
		for (int i = 0; i < 6; i++) bit_out(i[0] == 1'b0);
		bit_out(1'b1);
		bit_out(1'b1);
	endtask

	task automatic idle(input int bits);
		half(1'b1, 8 * bits);
	endtask

	task automatic glitch();
		logic lv;
		lv = line;
		half(!lv, 2);
		half(lv, 4);
	endtask

	// waveform faults
	// Kind 1 stuck low after edge fall, 2 fall after missing fall, 3 stuck low after mid fall
	task automatic fault(input int kind);
		if (kind == 1) begin
			half(1'b0, 12);
		end else if (kind == 2) begin
			half(1'b1, 8);
			half(1'b0, 4);
		end else if (kind == 3) begin
			half(1'b1, 4);
			half(1'b0, 14);
		end else begin
			glitch();
		end
	endtask
endmodule // csc_line_station

// [sim/test_csc_line_access.sv]
/*
 Self-checking bench for the line-access front end: registers, space timing,
 receive path and collision response.
 Assumes one 10 MHz clock and the station model on the receive pin.
*/
`timescale 1ns/1ps
module test_csc_line_access
	import csc_pkg::*;
;
	logic         clk = 1'b0;
	logic         sys_rst = 1'b1;
	logic [3:0]   avs_address = 4'h0;
	logic         avs_read = 1'b0;
	logic         avs_write = 1'b0;
	logic [31:0]  avs_writedata = 32'h0;
	logic [31:0]  avs_readdata;
	logic         avs_waitrequest;
	logic         line;
	logic         tx_start = 1'b0;
	logic         tx_active = 1'b0;
	logic         tx_permit;
	logic         manchester_sel;
	logic         collision;
	logic         resolution_join;
	csc_rx_byte_t rx_byte;
	int           err_count = 0;
	int           samples_checked = 0;
	int           n_coll = 0;
	int           n_join = 0;
	int           cyc = 0;
	int           t0;
	int           seed = 32'h1a46;
	logic [7:0]   exp_q[$];
	logic [7:0]   ifs_w[3] = '{8'h03, 8'h04, 8'h01};
	int           ifs_bits[3] = '{2, 4, 256};

	// 100 ns clock
	always #50 clk = ~clk;

	csc_line_access i_csc_line_access (
		.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.serial_receive_pin(line), .tx_start(tx_start), .tx_active(tx_active),
		.tx_permit(tx_permit), .manchester_sel(manchester_sel), .collision(collision),
		.resolution_join(resolution_join), .rx_byte(rx_byte)
	);
	csc_line_station i_csc_line_station (.clk(clk), .line(line));

	task automatic conclude();
		$display("mismatches %0d comparisons %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
			err_count++;
		end
	endtask

	task automatic near(input string nm, input int got, input int ex, input int tol);
		chk(nm, 32'(ex), (got >= ex - tol && got <= ex + tol) ? 32'(ex) : 32'(got));
	endtask

	// Pulse and tally counters
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (collision === 1'b1)
			n_coll <= n_coll + 1;
		if (resolution_join === 1'b1)
			n_join <= n_join + 1;
	end

	// Oldest noted byte against each delivered byte
	always @(posedge clk) begin
		if (rx_byte.valid === 1'b1) begin
			if (exp_q.size() == 0)
				chk("rx_byte.valid", 32'h0, 32'h1);
			else
				chk("rx_byte.data", {24'h0, exp_q.pop_front()}, {24'h0, rx_byte.data});
		end
	end

	// Bus access held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		q = avs_readdata;
		if (n >= 40) begin
			err_count++;
			conclude();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] ex, input string nm);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, ex, q & m);
	endtask

	task automatic start_tx();
		tx_start <= 1'b1;
		@(posedge clk);
		tx_start <= 1'b0;
		// Let the space timer reload before anything is measured
		@(posedge clk);
	endtask

	task automatic wait_permit();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (n > 4000) begin
				err_count++;
				conclude();
			end
		end while (tx_permit !== 1'b1);
	endtask

	// Collision from a chosen point of a frame; ex is {abort flag, receiver enable}
	task automatic collide(input logic [31:0] ctl, input int nb, input int ej, input logic [31:0] ex, input int kind);
		int c0;
		int j0;
		logic [31:0] s;
		logic [31:0] q;
		wreg(OFF_CTRL, ctl);
		wreg(OFF_STATUS, 32'h7);
		c0 = n_coll;
		j0 = n_join;
		if (nb > 0) begin
			s = 32'($random(seed));
			if (nb >= 24)
				exp_q.push_back(s[7:0]);
			i_csc_line_station.preamble();
			i_csc_line_station.byte_out(s[7:0]);
			i_csc_line_station.crc_out(32'($random(seed)), nb - 8);
			i_csc_line_station.bit_out(1'b1);
		end
		i_csc_line_station.fault(kind);
		i_csc_line_station.idle(4);
		chk("collision pulses", 32'h1, 32'(n_coll - c0));
		chk("join pulses", 32'(ej), 32'(n_join - j0));
		bus(1'b0, OFF_STATUS, 32'h0, s);
		bus(1'b0, OFF_CTRL, 32'h0, q);
		chk("abort and enable", ex, {30'h0, s[ST_RX_ABORT], q[6]});
	endtask

	// Watchdog
	initial begin
		#10_000_000;
		err_count++;
		conclude();
	end

	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		t0 = cyc;
		rdchk(OFF_IFS, 32'hFF, 32'h01, "ifs after reset");
		rdchk(4'h2, 32'hFFFF_FFFF, 32'h0, "unmapped read");
		rdchk(OFF_CTRL, 32'hFF, 32'h0, "ctrl after reset");
		wait_permit();
		near("first space", cyc - t0, 2048, 6);
		foreach (ifs_w[k]) begin
			wreg(OFF_IFS, {24'h0, ifs_w[k]});
			start_tx();
			t0 = cyc;
			rdchk(OFF_IFS, 32'hFF, {24'h0, ifs_w[k] | 8'h01}, "ifs first half");
			wait_permit();
			near("space length", cyc - t0, ifs_bits[k] * SAMPLES_PER_BIT, 4);
			rdchk(OFF_IFS, 32'hFF, {24'h0, ifs_w[k] & 8'hFE}, "ifs second half");
		end
		wreg(OFF_CTRL, 32'h3);
		@(posedge clk);
		chk("manchester with ext clock", 32'h0, {31'h0, manchester_sel});
		rdchk(OFF_STATUS, 32'h10, 32'h10, "unsupported flag");
		wreg(OFF_CTRL, 32'h1);
		@(posedge clk);
		chk("manchester in csma", 32'h1, {31'h0, manchester_sel});
		wreg(OFF_IFS, 32'h8);
		start_tx();
		i_csc_line_station.preamble();
		i_csc_line_station.byte_out(8'hA5);
		chk("permit during frame", 32'h0, {31'h0, tx_permit});
		t0 = cyc;
		wait_permit();
		near("deferral after frame", cyc - t0, 82, 10);
		// Alternate backoff: activity in the first half does not restart the space
		wreg(OFF_CTRL, 32'hD);
		start_tx();
		t0 = cyc;
		fork
			begin
				i_csc_line_station.preamble();
				i_csc_line_station.byte_out(8'h5A);
				i_csc_line_station.idle(4);
			end
			begin
				wait_permit();
				near("alt space on busy line", cyc - t0, 65, 4);
			end
		join
		for (int c = 0; c < 2; c++) begin
			wreg(OFF_CTRL, c ? 32'h61 : 32'h41);
			wreg(OFF_STATUS, 32'h7);
			t0 = $random(seed);
			exp_q.push_back(t0[7:0]);
			i_csc_line_station.preamble();
			i_csc_line_station.byte_out(t0[7:0]);
			i_csc_line_station.crc_out(32'($random(seed)), c ? 32 : 16);
			i_csc_line_station.idle(4);
			rdchk(OFF_RXDATA, 32'hFF, {24'h0, t0[7:0]}, "rx data reg");
			rdchk(OFF_STATUS, 32'h1, 32'h1, "line idle set");
			wreg(OFF_STATUS, 32'h1);
			rdchk(OFF_STATUS, 32'h1, 32'h0, "line idle cleared");
		end
		collide(32'h01, 0, 0, 32'h0, 0);
		collide(32'h11, 0, 1, 32'h0, 0);
		collide(32'h41, 12, 0, 32'h1, 0);
		collide(32'h51, 24, 1, 32'h2, 0);
		collide(32'h01, 12, 0, 32'h0, 1);
		collide(32'h41, 12, 0, 32'h1, 2);
		collide(32'h01, 12, 0, 32'h0, 3);
		chk("bytes outstanding", 32'h0, 32'(exp_q.size()));
		conclude();
	end
endmodule // test_csc_line_access
